// ===== hdl/qamc_defines.svh
// offsets, field positions, reset values and decode constants of the mode registers
`ifndef QAMC_DEFINES_SVH
`define QAMC_DEFINES_SVH

// ------------------------------------------------------------
// serial register addresses
// ------------------------------------------------------------
`define QAMC_ADDR_RESET      7'h00
`define QAMC_ADDR_FMT        7'h01
`define QAMC_ADDR_OMODE      7'h02
`define QAMC_ADDR_TPH        7'h03
`define QAMC_ADDR_TPL        7'h04

// ------------------------------------------------------------
// field positions
// ------------------------------------------------------------
`define QAMC_SWRST_BIT       7
`define QAMC_FMT_STAB_BIT    7
`define QAMC_FMT_OUTPUT_RANDOMIZER_BIT    6
`define QAMC_FMT_CODING_BIT  5
`define QAMC_FMT_SLEEP_BIT   4
`define QAMC_FMT_NAP_MSB     3
`define QAMC_OM_CUR_MSB      7
`define QAMC_OM_CUR_LSB      5
`define QAMC_OM_TERM_BIT     4
`define QAMC_OM_OFF_BIT      3
`define QAMC_OM_LANE_MSB     2
`define QAMC_TPH_EN_BIT      7
`define QAMC_TPH_PAT_MSB     5

// ------------------------------------------------------------
// reset values, the 03h write mask and frame counts
// ------------------------------------------------------------
`define QAMC_REG_RESET       8'h00
`define QAMC_TPH_MASK        8'hBF
`define QAMC_CNT_ADDR_LAST   5'h07
`define QAMC_CNT_DATA_LAST   5'h0F

// ------------------------------------------------------------
// driver current codes and currents in 10 uA units
// ------------------------------------------------------------
`define QAMC_CUR_RSVD        3'h3
`define QAMC_CUR_UA_000      10'h15E
`define QAMC_CUR_UA_001      10'h190
`define QAMC_CUR_UA_010      10'h1C2
`define QAMC_CUR_UA_100      10'h12C
`define QAMC_CUR_UA_101      10'h0FA
`define QAMC_CUR_UA_110      10'h0D2
`define QAMC_CUR_UA_111      10'h0AF

// ------------------------------------------------------------
// lane mode codes and frame widths
// ------------------------------------------------------------
`define QAMC_LANE_2_16       3'h0
`define QAMC_LANE_2_14       3'h1
`define QAMC_LANE_2_12       3'h2
`define QAMC_LANE_1_14       3'h5
`define QAMC_LANE_1_12       3'h6
`define QAMC_LANE_1_16       3'h7
`define QAMC_FRAME_16        5'h10
`define QAMC_FRAME_14        5'h0E
`define QAMC_FRAME_12        5'h0C

`endif

// ===== hdl/qamc_pkg.sv
// types shared by the mode control register bank
package qamc_pkg;

	typedef logic [7:0]  qamc_byte_t;
	typedef logic [6:0]  qamc_addr_t;
	typedef logic [13:0] qamc_sample_t;

	// serial frame phases
	typedef enum logic [3:0] {
		QAMC_ST_IDLE = 4'h1,
		QAMC_ST_CMD  = 4'h2,
		QAMC_ST_DATA = 4'h4,
		QAMC_ST_DONE = 4'h8
	} qamc_frame_st_e;

endpackage : qamc_pkg

// ===== hdl/qamc_cfg_if.sv
// decoded serial command handed from the frame receiver to the register bank
`timescale 1ns/100ps
interface qamc_cfg_if;
	import qamc_pkg::*;

	logic       addr_pulse;
	logic       frame_done;
	logic       cmd_rw;
	qamc_addr_t cmd_addr;
	qamc_byte_t wr_data;
	qamc_byte_t rd_data;

	modport frame (output addr_pulse, output frame_done, output cmd_rw,
		output cmd_addr, output wr_data, input rd_data);
	modport regs (input addr_pulse, input frame_done, input cmd_rw,
		input cmd_addr, input wr_data, output rd_data);

endinterface : qamc_cfg_if

// ===== hdl/qamc_spi_frame.sv
// serial frame receiver: 16-bit command in, read data out on open-drain line
`timescale 1ns/100ps
`include "qamc_defines.svh"
module qamc_spi_frame
	import qamc_pkg::*;
(
	input  wire logic   ref_clk,
	input  wire logic   rst_b,
	input  wire logic   clk_en,
	input  wire logic   cs_b,
	input  wire logic   sck,
	input  wire logic   serial_data_in,
	output logic        sdo_out,
	output logic        sdo_oe_b,
	qamc_cfg_if.frame   cfg
);

	// ------------------------------------------------------------
	// edge detect and phase tracking
	// ------------------------------------------------------------
	logic           sck_q_r;
	logic           sck_rise;
	logic           sck_fall;
	logic [4:0]     cnt_r;
	logic [15:0]    shift_r;
	logic [7:0]     out_r;
	logic           read_act_r;
	qamc_frame_st_e st_r;
	qamc_frame_st_e st_nxt;

	assign sck_rise = sck & ~sck_q_r;
	assign sck_fall = ~sck & sck_q_r;

	// previous clock level, pins taken as synchronous
	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b)
			sck_q_r <= 1'b0;
		else if (clk_en)
			sck_q_r <= sck;
	end

	// frame phase; edges past the sixteenth park in done
	always_comb begin
		st_nxt = st_r;
		case (st_r)
			QAMC_ST_IDLE: if (!cs_b) st_nxt = QAMC_ST_CMD;
			QAMC_ST_CMD: begin
				if (cs_b)
					st_nxt = QAMC_ST_IDLE;
				else if (sck_rise && cnt_r == `QAMC_CNT_ADDR_LAST)
					st_nxt = QAMC_ST_DATA;
			end
			QAMC_ST_DATA: begin
				if (cs_b)
					st_nxt = QAMC_ST_IDLE;
				else if (sck_rise && cnt_r == `QAMC_CNT_DATA_LAST)
					st_nxt = QAMC_ST_DONE;
			end
			QAMC_ST_DONE: if (cs_b) st_nxt = QAMC_ST_IDLE;
			default:      st_nxt = QAMC_ST_IDLE;
		endcase
	end

	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b)
			st_r <= QAMC_ST_IDLE;
		else if (clk_en)
			st_r <= st_nxt;
	end

	// ------------------------------------------------------------
	// bit capture
	// ------------------------------------------------------------
	// sample on rising edges while selected, first bit lands highest
	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			cnt_r   <= 5'h00;
			shift_r <= 16'h0000;
		end else if (clk_en) begin
			if (st_r == QAMC_ST_IDLE)
				cnt_r <= 5'h00;
			else if (sck_rise && (st_r == QAMC_ST_CMD || st_r == QAMC_ST_DATA)) begin
				cnt_r   <= cnt_r + 5'h01;
				shift_r <= {shift_r[14:0], serial_data_in};
			end
		end
	end

	// command after eight bits, data after sixteen; pulses last one cycle
	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			cfg.addr_pulse <= 1'b0;
			cfg.frame_done <= 1'b0;
			cfg.cmd_rw     <= 1'b0;
			cfg.cmd_addr   <= 7'h00;
			cfg.wr_data    <= 8'h00;
		end else if (clk_en) begin
			cfg.addr_pulse <= 1'b0;
			cfg.frame_done <= 1'b0;
			if (st_r == QAMC_ST_CMD && sck_rise && cnt_r == `QAMC_CNT_ADDR_LAST) begin
				cfg.addr_pulse <= 1'b1;
				cfg.cmd_rw     <= shift_r[6];
				cfg.cmd_addr   <= {shift_r[5:0], serial_data_in};
			end
			if (st_r == QAMC_ST_DATA && sck_rise && cnt_r == `QAMC_CNT_DATA_LAST) begin
				cfg.frame_done <= 1'b1;
				cfg.wr_data    <= {shift_r[6:0], serial_data_in};
			end
		end
	end

	// ------------------------------------------------------------
	// read back, open drain: enable low pulls the line to zero
	// ------------------------------------------------------------
	// load one cycle after the address, shift on falling edges
	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			read_act_r <= 1'b0;
			out_r      <= 8'h00;
			sdo_oe_b   <= 1'b1;
		end else if (clk_en) begin
			if (cs_b) begin
				read_act_r <= 1'b0;
				sdo_oe_b   <= 1'b1;
			end else if (cfg.addr_pulse && cfg.cmd_rw) begin
				read_act_r <= 1'b1;
				out_r      <= cfg.rd_data;
				sdo_oe_b   <= cfg.rd_data[7];
			end else if (read_act_r && sck_fall && st_r == QAMC_ST_DATA) begin
				out_r    <= {out_r[6:0], 1'b0};
				sdo_oe_b <= out_r[6];
			end
		end
	end

	// the pin only ever pulls low
	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b)
			sdo_out <= 1'b0;
		else if (clk_en)
			sdo_out <= 1'b0;
	end

endmodule : qamc_spi_frame

// ===== hdl/qamc_regs.sv
// mode control register bank of a four-channel serial-output converter
// Functional notes
// - coding bit: offset binary or two's complement
// - power field zero runs; nap bits per channel
// - sleep bit disables all channels regardless
// - any nap combination accepted together
// - current field selects driver current
// - termination bit on doubles driver current
// - output mode register at address 02h
// - bit 7 at 03h enables test pattern
// - 03h low six bits give pattern 13:8
// - 04h gives pattern bits 7:0
// - bit 6 at 03h unused, no effect
// - 16-bit frame on rising edges, extras ignored
// - low flag writes, high flag reads back
// - reset bit clears all registers, self-clearing
// - format and power register at address 01h
`timescale 1ns/100ps
`include "qamc_defines.svh"
module qamc_regs
	import qamc_pkg::*;
(
	input  wire logic                ref_clk,
	input  wire logic                rst_b,
	input  wire logic                clk_en,
	input  wire logic                cs_b,
	input  wire logic                sck,
	input  wire logic                serial_data_in,
	output logic                     serial_data_out,
	output logic                     serial_data_out_oe_b,
	input  wire logic [3:0][13:0]    sample_in,
	input  wire logic                sample_valid_in,
	output logic [3:0][13:0]         chan_data_r,
	output logic [3:0]               chan_valid_r,
	output logic                     data_out_enable_r,
	output logic [3:0]               channel_active_r,
	output logic                     sleep_mode_r,
	output logic                     output_coding_select_r,
	output logic                     clock_stabilizer_off_r,
	output logic                     output_randomizer_r,
	output logic [2:0]               driver_current_field_r,
	output logic                     internal_termination_enable_r,
	output logic [9:0]               driver_current_r,
	output logic                     current_code_invalid_r,
	output logic                     two_lane_r,
	output logic [4:0]               frame_width_r,
	output logic                     lane_mode_valid_r,
	output logic                     test_pattern_enable_r,
	output logic [13:0]              pattern_word_r
);

	// ------------------------------------------------------------
	// serial frame receiver
	// ------------------------------------------------------------
	qamc_cfg_if cfg ();

	qamc_spi_frame u_frame (
		.ref_clk        (ref_clk),
		.rst_b          (rst_b),
		.clk_en         (clk_en),
		.cs_b           (cs_b),
		.sck            (sck),
		.serial_data_in (serial_data_in),
		.sdo_out        (serial_data_out),
		.sdo_oe_b       (serial_data_out_oe_b),
		.cfg            (cfg.frame)
	);

	// ------------------------------------------------------------
	// register storage
	// ------------------------------------------------------------
	qamc_byte_t fmt_r;
	qamc_byte_t omode_r;
	qamc_byte_t tph_r;
	qamc_byte_t tpl_r;
	logic       wr_stb;
	logic       soft_rst;

	// a write lands only once all sixteen bits are
	assign wr_stb   = cfg.frame_done & ~cfg.cmd_rw;
	// reset bit is write-only, nothing stores it so it reads back zero
	assign soft_rst = wr_stb & (cfg.cmd_addr == `QAMC_ADDR_RESET)
		& cfg.wr_data[`QAMC_SWRST_BIT];

	// addressed writes; software reset clears every mode register
	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			fmt_r   <= `QAMC_REG_RESET;
			omode_r <= `QAMC_REG_RESET;
			tph_r   <= `QAMC_REG_RESET;
			tpl_r   <= `QAMC_REG_RESET;
		end else if (clk_en) begin
			if (soft_rst) begin
				fmt_r   <= `QAMC_REG_RESET;
				omode_r <= `QAMC_REG_RESET;
				tph_r   <= `QAMC_REG_RESET;
				tpl_r   <= `QAMC_REG_RESET;
			end else if (wr_stb) begin
				case (cfg.cmd_addr)
					`QAMC_ADDR_FMT:   fmt_r   <= cfg.wr_data;
					`QAMC_ADDR_OMODE: omode_r <= cfg.wr_data;
					`QAMC_ADDR_TPH:   tph_r   <= cfg.wr_data & `QAMC_TPH_MASK;
					`QAMC_ADDR_TPL:   tpl_r   <= cfg.wr_data;
					default:          ;
				endcase
			end
		end
	end

	// read mux; unmapped and write-only addresses answer zero
	always_comb begin
		case (cfg.cmd_addr)
			`QAMC_ADDR_FMT:   cfg.rd_data = fmt_r;
			`QAMC_ADDR_OMODE: cfg.rd_data = omode_r;
			`QAMC_ADDR_TPH:   cfg.rd_data = tph_r;
			`QAMC_ADDR_TPL:   cfg.rd_data = tpl_r;
			default:          cfg.rd_data = 8'h00;
		endcase
	end

	// ------------------------------------------------------------
	// format and power decode
	// ------------------------------------------------------------
	// sleep overrides every nap bit; naps are independent per channel
	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			sleep_mode_r     <= 1'b0;
			channel_active_r <= 4'hF;
		end else if (clk_en) begin
			sleep_mode_r <= fmt_r[`QAMC_FMT_SLEEP_BIT];
			if (fmt_r[`QAMC_FMT_SLEEP_BIT])
				channel_active_r <= 4'h0;
			else
				channel_active_r <= ~fmt_r[`QAMC_FMT_NAP_MSB:0];
		end
	end

	// coding, the clock stabilizer control and the output randomizer pass straight out
	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			output_coding_select_r <= 1'b0;
			clock_stabilizer_off_r <= 1'b0;
			output_randomizer_r    <= 1'b0;
		end else if (clk_en) begin
			output_coding_select_r <= fmt_r[`QAMC_FMT_CODING_BIT];
			clock_stabilizer_off_r <= fmt_r[`QAMC_FMT_STAB_BIT];
			output_randomizer_r    <= fmt_r[`QAMC_FMT_OUTPUT_RANDOMIZER_BIT];
		end
	end

	// ------------------------------------------------------------
	// output driver decode
	// ------------------------------------------------------------
	logic [9:0] cur_base;

	// nominal current per code in 10 uA steps; code 011 has no meaning
	always_comb begin
		case (omode_r[`QAMC_OM_CUR_MSB:`QAMC_OM_CUR_LSB])
			3'h0:    cur_base = `QAMC_CUR_UA_000;
			3'h1:    cur_base = `QAMC_CUR_UA_001;
			3'h2:    cur_base = `QAMC_CUR_UA_010;
			3'h4:    cur_base = `QAMC_CUR_UA_100;
			3'h5:    cur_base = `QAMC_CUR_UA_101;
			3'h6:    cur_base = `QAMC_CUR_UA_110;
			3'h7:    cur_base = `QAMC_CUR_UA_111;
			default: cur_base = 10'h000;
		endcase
	end

	// termination doubles the drive; the field alone cannot exceed 450
	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			driver_current_field_r        <= 3'h0;
			internal_termination_enable_r <= 1'b0;
			driver_current_r              <= `QAMC_CUR_UA_000;
			current_code_invalid_r        <= 1'b0;
		end else if (clk_en) begin
			driver_current_field_r        <= omode_r[`QAMC_OM_CUR_MSB:`QAMC_OM_CUR_LSB];
			internal_termination_enable_r <= omode_r[`QAMC_OM_TERM_BIT];
			driver_current_r <= omode_r[`QAMC_OM_TERM_BIT] ?
				{cur_base[8:0], 1'b0} : cur_base;
			// flagged so a misbehaving host shows up, the drive stays at zero
			current_code_invalid_r <= (omode_r[`QAMC_OM_CUR_MSB:`QAMC_OM_CUR_LSB]
				== `QAMC_CUR_RSVD);
		end
	end

	// lane and frame width; unused codes fall back to two lanes, 16 bits
	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			two_lane_r        <= 1'b1;
			frame_width_r     <= `QAMC_FRAME_16;
			lane_mode_valid_r <= 1'b1;
		end else if (clk_en) begin
			lane_mode_valid_r <= 1'b1;
			case (omode_r[`QAMC_OM_LANE_MSB:0])
				`QAMC_LANE_2_16: begin
					two_lane_r    <= 1'b1;
					frame_width_r <= `QAMC_FRAME_16;
				end
				`QAMC_LANE_2_14: begin
					two_lane_r    <= 1'b1;
					frame_width_r <= `QAMC_FRAME_14;
				end
				`QAMC_LANE_2_12: begin
					two_lane_r    <= 1'b1;
					frame_width_r <= `QAMC_FRAME_12;
				end
				`QAMC_LANE_1_14: begin
					two_lane_r    <= 1'b0;
					frame_width_r <= `QAMC_FRAME_14;
				end
				`QAMC_LANE_1_12: begin
					two_lane_r    <= 1'b0;
					frame_width_r <= `QAMC_FRAME_12;
				end
				`QAMC_LANE_1_16: begin
					two_lane_r    <= 1'b0;
					frame_width_r <= `QAMC_FRAME_16;
				end
				default: begin
					two_lane_r        <= 1'b1;
					frame_width_r     <= `QAMC_FRAME_16;
					lane_mode_valid_r <= 1'b0;
				end
			endcase
		end
	end

	// ------------------------------------------------------------
	// test pattern
	// ------------------------------------------------------------
	// bit 6 of the high register never reaches the pattern word
	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			test_pattern_enable_r <= 1'b0;
			pattern_word_r        <= 14'h0000;
		end else if (clk_en) begin
			test_pattern_enable_r <= tph_r[`QAMC_TPH_EN_BIT];
			pattern_word_r <= {tph_r[`QAMC_TPH_PAT_MSB:0], tpl_r};
		end
	end

	// ------------------------------------------------------------
	// channel data path
	// ------------------------------------------------------------
	// per channel: napped or sleeping channels go quiet, pattern wins
	// over samples, and coding flips the sample sign bit only; the
	// pattern is sent as programmed so the host sees its exact word
	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			chan_data_r       <= '0;
			chan_valid_r      <= 4'h0;
			data_out_enable_r <= 1'b0;
		end else if (clk_en) begin
			data_out_enable_r <= ~omode_r[`QAMC_OM_OFF_BIT];
			for (int i = 0; i < 4; i++) begin
				if (omode_r[`QAMC_OM_OFF_BIT] || !channel_active_r[i]) begin
					chan_data_r[i]  <= 14'h0000;
					chan_valid_r[i] <= 1'b0;
				end else if (test_pattern_enable_r) begin
					chan_data_r[i]  <= pattern_word_r;
					chan_valid_r[i] <= sample_valid_in;
				end else begin
					chan_data_r[i]  <= {sample_in[i][13] ^ output_coding_select_r,
						sample_in[i][12:0]};
					chan_valid_r[i] <= sample_valid_in;
				end
			end
		end
	end

endmodule : qamc_regs

// ===== verif/qamc_regs_props.sv
// concurrent checks on the mode control register bank ports
`timescale 1ns/100ps
module qamc_regs_props
	import qamc_pkg::*;
(
	input wire logic             ref_clk,
	input wire logic             rst_b,
	input wire logic             clk_en,
	input wire logic             cs_b,
	input wire logic             sck,
	input wire logic             serial_data_in,
	input wire logic             serial_data_out,
	input wire logic             serial_data_out_oe_b,
	input wire logic [3:0][13:0] sample_in,
	input wire logic             sample_valid_in,
	input wire logic [3:0][13:0] chan_data_r,
	input wire logic [3:0]       chan_valid_r,
	input wire logic             data_out_enable_r,
	input wire logic [3:0]       channel_active_r,
	input wire logic             sleep_mode_r,
	input wire logic             output_coding_select_r,
	input wire logic             clock_stabilizer_off_r,
	input wire logic             output_randomizer_r,
	input wire logic [2:0]       driver_current_field_r,
	input wire logic             internal_termination_enable_r,
	input wire logic [9:0]       driver_current_r,
	input wire logic             current_code_invalid_r,
	input wire logic             two_lane_r,
	input wire logic [4:0]       frame_width_r,
	input wire logic             lane_mode_valid_r,
	input wire logic             test_pattern_enable_r,
	input wire logic [13:0]      pattern_word_r
);
	// driver current in 10 uA steps, doubled by termination
	function automatic logic [9:0] cur_of(input logic [2:0] c, input logic t);
		logic [9:0] v;
		case (c)
			3'h0: v = 10'h15E;
			3'h1: v = 10'h190;
			3'h2: v = 10'h1C2;
			3'h4: v = 10'h12C;
			3'h5: v = 10'h0FA;
			3'h6: v = 10'h0D2;
			3'h7: v = 10'h0AF;
			default: v = 10'h000;
		endcase
		return t ? {v[8:0], 1'b0} : v;
	endfunction : cur_of

	default clocking cb @(posedge ref_clk);
	endclocking
	default disable iff (!rst_b);

	a_sleep_all_off: assert property (
		sleep_mode_r && $past(sleep_mode_r) |-> channel_active_r == 4'h0)
		else $error("channel running in sleep");
	// settled field gives the decoded current
	a_current_sel: assert property (
		$stable(driver_current_field_r) && $stable(internal_termination_enable_r)
		|-> driver_current_r == cur_of(driver_current_field_r, internal_termination_enable_r)
		&& current_code_invalid_r == (driver_current_field_r == 3'h3))
		else $error("driver current mismatch");
	a_lane_unused: assert property (
		!lane_mode_valid_r |-> two_lane_r && frame_width_r == 5'h10)
		else $error("unused lane code not defaulted");
	a_off_no_valid: assert property (
		!data_out_enable_r && !$past(data_out_enable_r) |-> chan_valid_r == 4'h0)
		else $error("valid data while outputs off");
	a_pattern_out: assert property (
		test_pattern_enable_r && $past(test_pattern_enable_r) && $stable(pattern_word_r)
		&& chan_valid_r[0] |-> chan_data_r[0] == pattern_word_r)
		else $error("pattern not on channel output");
	a_cs_release: assert property (
		cs_b && $past(cs_b) && $past(cs_b, 2) |-> serial_data_out_oe_b)
		else $error("readback line held while deselected");
	a_sdo_low: assert property (
		!serial_data_out_oe_b |-> serial_data_out == 1'b0)
		else $error("open drain drives high");
	// pattern word, coding and current field hold while the host is deselected
	a_idle_hold: assert property (
		cs_b && $past(cs_b) |-> $stable(pattern_word_r)
		&& $stable(output_coding_select_r) && $stable(driver_current_field_r))
		else $error("register changed outside a frame");
endmodule : qamc_regs_props

// ===== verif/qamc_host_model.sv
// serial configuration host sending 16-bit command frames
`timescale 1ns/100ps
module qamc_host_model
	import qamc_pkg::*;
(
	input  wire logic ref_clk,
	input  wire logic sdo_line,
	output logic      cs_b,
	output logic      sck,
	output logic      serial_data_in
);
	// deselected with the serial clock parked low
	initial begin
		cs_b = 1'b1;
		sck = 1'b0;
		serial_data_in = 1'b0;
	end

	// wait n edges, then step just past the edge
	task automatic tick(input int n);
		repeat (n) @(posedge ref_clk);
		#1;
	endtask : tick

	// msb first, ph cycles per phase; nb below 16 aborts the frame
	task automatic xfer(input logic [15:0] w, input int nb, input int ph,
		output logic [7:0] rd);
		rd = 8'h00;
		cs_b = 1'b0;
		for (int i = 0; i < nb; i++) begin
			serial_data_in = (i < 16) ? w[15-i] : ~serial_data_in;
			tick(ph);
			sck = 1'b1;
			tick(ph);
			// the bank steps to its next bit on each fall, so take it while high
			if (i >= 7 && i < 15) rd = {rd[6:0], sdo_line};
			sck = 1'b0;
		end
		tick(ph);
		cs_b = 1'b1;
		serial_data_in = ~serial_data_in; // released line shows no stale bit
		tick(2);
	endtask : xfer
endmodule : qamc_host_model

// ===== verif/tb.sv
// self-checking bench for the mode control register bank
`timescale 1ns/100ps
module tb;
	import qamc_pkg::*;
	logic ref_clk = 1'b0, rst_b = 1'b0, clk_en = 1'b1, sample_valid_in = 1'b1;
	logic cs_b, sck, serial_data_in, serial_data_out, serial_data_out_oe_b, sdo_line;
	logic [3:0][13:0] sample_in = '0, chan_data_r;
	logic [3:0] chan_valid_r, channel_active_r;
	logic data_out_enable_r, sleep_mode_r, output_coding_select_r, clock_stabilizer_off_r;
	logic output_randomizer_r, internal_termination_enable_r, current_code_invalid_r;
	logic two_lane_r, lane_mode_valid_r, test_pattern_enable_r;
	logic [2:0] driver_current_field_r;
	logic [9:0] driver_current_r;
	logic [4:0] frame_width_r;
	logic [13:0] pattern_word_r;
	logic [7:0] f, o, h, l, x; // shadow copies of 01h..04h; x holds read data
	logic [31:0] seed = 32'h00009C67;
	int n_mismatch = 0, n_compared = 0, cyc = 0;

	qamc_regs dut (.*);
	qamc_host_model host (.*);
	// readback line with its pull-up
	assign sdo_line = serial_data_out_oe_b ? 1'b1 : serial_data_out;

	// ---------------------------------------------------------
	// clock, timeout, helpers
	// ---------------------------------------------------------
	always #2 ref_clk = ~ref_clk;
	always @(posedge ref_clk) begin
		cyc++;
		if (cyc == 60000) begin
			n_mismatch++;
			conclude();
		end
	end
	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction : rnd
	// lanes, frame width, code valid
	function automatic logic [6:0] lane(input logic [2:0] m);
		case (m)
			3'h0: return {1'b1, 5'h10, 1'b1};
			3'h1: return {1'b1, 5'h0E, 1'b1};
			3'h2: return {1'b1, 5'h0C, 1'b1};
			3'h5: return {1'b0, 5'h0E, 1'b1};
			3'h6: return {1'b0, 5'h0C, 1'b1};
			3'h7: return {1'b0, 5'h10, 1'b1};
			default: return {1'b1, 5'h10, 1'b0};
		endcase
	endfunction : lane
	// nominal driver current in 10 uA steps, zero for the unused code
	function automatic logic [9:0] cur_ua(input logic [2:0] c);
		case (c)
			3'h0: return 10'h15E;
			3'h1: return 10'h190;
			3'h2: return 10'h1C2;
			3'h4: return 10'h12C;
			3'h5: return 10'h0FA;
			3'h6: return 10'h0D2;
			3'h7: return 10'h0AF;
			default: return 10'h000;
		endcase
	endfunction : cur_ua
	task automatic chk(input logic [15:0] g, input logic [15:0] e);
		n_compared++;
		if (g !== e) begin
			n_mismatch++;
			$display("wrong value at %0t: got %h expected %h", $time, g, e);
		end
	endtask : chk
	task automatic wr(input logic [6:0] a, input logic [7:0] d);
		host.xfer({1'b0, a, d}, 16, 4 + (rnd() & 3), x);
	endtask : wr
	task automatic rdchk(input logic [6:0] a, input logic [7:0] e);
		host.xfer({1'b1, a, 8'(rnd() >> 24)}, 16, 4 + (rnd() & 3), x);
		chk(x, e);
	endtask : rdchk
	task automatic wr_all();
		wr(7'h01, f);
		wr(7'h02, o);
		wr(7'h03, h);
		wr(7'h04, l);
	endtask : wr_all
	task automatic rd_all();
		rdchk(7'h01, f);
		rdchk(7'h02, o);
		rdchk(7'h03, h & 8'hBF);
		rdchk(7'h04, l);
	endtask : rd_all
	// derived outputs worked out from the shadow registers
	task automatic expect_all();
		logic [3:0] act;
		logic v;
		act = f[4] ? 4'h0 : ~f[3:0];
		host.tick(4);
		chk({clock_stabilizer_off_r, output_randomizer_r, output_coding_select_r,
			sleep_mode_r, channel_active_r}, {f[7:4], act});
		chk({driver_current_field_r, internal_termination_enable_r, data_out_enable_r},
			{o[7:4], ~o[3]});
		chk({current_code_invalid_r, driver_current_r},
			{o[7:5] == 3'h3, cur_ua(o[7:5]) << o[4]});
		chk({test_pattern_enable_r, pattern_word_r}, {h[7], h[5:0], l});
		chk({two_lane_r, frame_width_r, lane_mode_valid_r}, lane(o[2:0]));
		for (int i = 0; i < 4; i++) begin
			v = sample_valid_in & act[i] & ~o[3];
			chk({chan_valid_r[i], chan_data_r[i]}, !v ? 15'h0000 : h[7] ? {1'b1, h[5:0], l}
				: {1'b1, sample_in[i] ^ {f[5], 13'h0000}});
		end
	endtask : expect_all
	task automatic conclude();
		$display("compared %0d mismatched %0d", n_compared, n_mismatch);
		if (n_mismatch == 0 && n_compared > 0) $display("Testbench passed");
		else $display("Testbench failed");
		$finish;
	endtask : conclude

	// ---------------------------------------------------------
	// main sequence
	// ---------------------------------------------------------
	initial begin
		host.tick(2);
		rst_b = 1'b1;
		wr(7'h00, 8'h80);
		{f, o, h, l} = '0;
		rd_all();
		for (int k = 0; k < 14; k++) begin
			{f, o, h, l} = rnd();
			if (k == 0) {f, o, h, l} = 32'h20000000;
			if (k == 1) {f, o, h, l} = 32'h0AF0BFFF;
			if (k == 2) {f, o, h, l} = 32'h9FA40000;
			if (o[7:5] == 3'h3) o[7:5] = 3'h7;
			if (o[7:5] < 3'h5) o[4] = 1'b0;
			sample_in = 56'({rnd(), rnd()});
			wr_all();
			expect_all();
			rd_all();
		end
		host.xfer({1'b0, 7'h04, ~l}, 10, 4, x);
		host.xfer({1'b0, 7'h04, 8'h3C}, 18, 5, x);
		l = 8'h3C;
		wr(7'h05, 8'hFF);
		wr(7'h00, 8'h7F);
		rdchk(7'h05, 8'h00);
		rd_all();
		// deliberate reserved current code
		wr(7'h02, 8'h70);
		o = 8'h70;
		expect_all();
		clk_en = 1'b0;
		sample_valid_in = 1'b0;
		host.tick(5);
		chk(chan_valid_r, {4{~o[3]}} & (f[4] ? 4'h0 : ~f[3:0]));
		clk_en = 1'b1;
		sample_valid_in = 1'b1;
		wr(7'h00, 8'h80);
		{f, o, h, l} = '0;
		expect_all();
		rd_all();
		wr(7'h01, 8'h3F);
		rst_b = 1'b0;
		host.tick(2);
		rst_b = 1'b1;
		expect_all();
		rd_all();
		conclude();
	end
endmodule : tb

bind qamc_regs qamc_regs_props u_props (.*);
